//--- ssw_pkg.sv
package ssw_pkg;
    // ------------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------------
    localparam longint CLK_FREQ_HZ = 250000000;
    localparam longint RESET_PULSE_MS = 200;
    localparam longint RESET_MIN_MS = 140;
    localparam longint WDOG_PERIOD_MS = 1600;
    localparam longint KICK_MIN_NS = 50;
    localparam longint RESET_PULSE_CYC = RESET_PULSE_MS * (CLK_FREQ_HZ / 1000);
    localparam longint WDOG_PERIOD_CYC = WDOG_PERIOD_MS * (CLK_FREQ_HZ / 1000);
    localparam longint KICK_MIN_CYC = (KICK_MIN_NS * 250 + 999) / 1000;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
    localparam logic RESET_N_RST = 1'b0;
    localparam logic WDOG_N_RST = 1'b0;
    localparam logic AUX_N_RST = 1'b0;

    typedef enum logic [1:0] {
        SSW_RST_HOLD = 2'b00,
        SSW_RST_STRETCH = 2'b01,
        SSW_RST_RUN = 2'b10
    } ssw_rst_state_t;
endpackage : ssw_pkg

//--- ssw_supervisor.sv
// Summary of operation
// - Hold reset while supply bad, release after 200ms.
// - Active-high reset is inverse of active-low reset.
// - Supply drop asserts reset immediately and holds.
// - Brownout during pulse continues at least 140ms.
// - Power-fail flag low while aux below trip.
// - Manual reset low triggers at least 140ms pulse.
// - No kick for 1.6s drives timeout low.
// - Timeout stays low until a kick edge, reset assertion or a floating kick input.
// - Floating kick input clears and stops watchdog.
// - Reset asserted clears and stops watchdog.
// - Any kick edge after reset starts countdown.
// - Each kick edge restarts full countdown.
// - Timeout low while supply bad, releases immediately.
// - Reset held 200ms after manual reset released.
module ssw_supervisor #(
    parameter logic [31:0] RESET_CYC = 32'(ssw_pkg::RESET_PULSE_CYC),
    parameter logic [31:0] WDOG_CYC = 32'(ssw_pkg::WDOG_PERIOD_CYC)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Analog front end levels
    input wire logic supply_good,
    input wire logic aux_below_trip,
    input wire logic kick_floating,
    // Pins
    input wire logic manual_reset_n,
    input wire logic watchdog_kick_in,
    output logic reset_n,
    output logic reset_p,
    output logic watchdog_timeout_n,
    output logic aux_fail_n
);
    import ssw_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Every external level passes two flops; edges are taken only from
    // the second stage and a third history flop.
    logic [4:0] sync1_reg, sync1_next;
    logic [4:0] sync2_reg, sync2_next;
    logic sup_ok, aux_low, kick_float, mr_low, kick_s;

    always_comb begin
        sync1_next = {supply_good, aux_below_trip, kick_floating,
                      manual_reset_n, watchdog_kick_in};
        sync2_next = sync1_reg;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_reg <= 5'h02;
            sync2_reg <= 5'h02;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    assign sup_ok = sync2_reg[4];
    assign aux_low = sync2_reg[3];
    assign kick_float = sync2_reg[2];
    assign mr_low = ~sync2_reg[1];
    assign kick_s = sync2_reg[0];

    // ------------------------------------------------------------------
    // Kick edge detector
    // ------------------------------------------------------------------
    // A 50 ns kick spans a dozen clocks, so any edge is seen. The history
    // flop resets to the synchroniser's own reset level, so no false edge
    // follows reset.
    logic kick_hist_reg, kick_hist_next;
    logic kick_edge;

    always_comb begin
        kick_hist_next = kick_s;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            kick_hist_reg <= 1'b0;
        end else begin
            kick_hist_reg <= kick_hist_next;
        end
    end

    assign kick_edge = kick_s ^ kick_hist_reg;

    // ------------------------------------------------------------------
    // Reset generator
    // ------------------------------------------------------------------
    // The stretch is a full 200 ms, which covers the 140 ms minimum and
    // rides out switch bounce: every low level restarts it.
    ssw_rst_state_t rst_state_reg, rst_state_next;
    logic [CNT_W-1:0] rst_cnt_reg, rst_cnt_next;
    logic reset_n_reg, reset_n_next;
    logic rst_req;
    logic stretch_done;

    // Either cause alone holds the state machine in its hold state.
    assign rst_req = !sup_ok || mr_low;

    // The last count of the stretch; the state moves on at this edge.
    assign stretch_done =
        (rst_cnt_reg >= RESET_CYC - 32'h0000_0001);

    // ------------------------------------------------------------------
    // Reset state
    // ------------------------------------------------------------------
    // Hold waits for every cause to clear, stretch times the pulse and
    // run leaves the processor free until the next request.
    always_comb begin
        rst_state_next = rst_state_reg;
        case (rst_state_reg)
            SSW_RST_HOLD: begin
                if (!rst_req) begin
                    rst_state_next = SSW_RST_STRETCH;
                end
            end
            SSW_RST_STRETCH: begin
                if (stretch_done) begin
                    rst_state_next = SSW_RST_RUN;
                end
            end
            SSW_RST_RUN: begin
                rst_state_next = SSW_RST_RUN;
            end
            default: begin
                rst_state_next = SSW_RST_HOLD;
            end
        endcase
        if (rst_req) begin
            rst_state_next = SSW_RST_HOLD;
        end
        reset_n_next = (rst_state_next == SSW_RST_RUN);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rst_state_reg <= SSW_RST_HOLD;
            reset_n_reg <= RESET_N_RST;
        end else begin
            rst_state_reg <= rst_state_next;
            reset_n_reg <= reset_n_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset stretch counter
    // ------------------------------------------------------------------
    // Cleared outside the stretch state, so a new request always restarts
    // the full interval instead of resuming a part-spent one.
    always_comb begin
        rst_cnt_next = CNT_ZERO;
        case (rst_state_reg)
            SSW_RST_HOLD: begin
                rst_cnt_next = CNT_ZERO;
            end
            SSW_RST_STRETCH: begin
                rst_cnt_next = rst_cnt_reg + 32'h0000_0001;
            end
            SSW_RST_RUN: begin
                rst_cnt_next = CNT_ZERO;
            end
            default: begin
                rst_cnt_next = CNT_ZERO;
            end
        endcase
        if (rst_req) begin
            rst_cnt_next = CNT_ZERO;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rst_cnt_reg <= CNT_ZERO;
        end else begin
            rst_cnt_reg <= rst_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog counter
    // ------------------------------------------------------------------
    // Counting starts only at the first kick edge after reset, so an idle
    // processor held in reset never sees a spurious timeout.
    logic wd_run_reg, wd_run_next;
    logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
    logic wd_hold;
    logic wd_expire;

    // A floating kick pin parks the watchdog just as reset does.
    assign wd_hold = !reset_n_reg || kick_float;
    assign wd_expire = wd_run_reg &&
                       (wd_cnt_reg >= WDOG_CYC - 32'h0000_0001);

    always_comb begin
        wd_run_next = wd_run_reg;
        wd_cnt_next = wd_cnt_reg;
        if (wd_hold) begin
            wd_run_next = 1'b0;
            wd_cnt_next = CNT_ZERO;
        end else if (kick_edge) begin
            wd_run_next = 1'b1;
            wd_cnt_next = CNT_ZERO;
        end else if (wd_expire) begin
            wd_run_next = 1'b0;
        end else if (wd_run_reg) begin
            wd_cnt_next = wd_cnt_reg + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wd_run_reg <= 1'b0;
            wd_cnt_reg <= CNT_ZERO;
        end else begin
            wd_run_reg <= wd_run_next;
            wd_cnt_reg <= wd_cnt_next;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog output
    // ------------------------------------------------------------------
    // There is no minimum pulse here: the output follows the supply at
    // once, unlike the stretched reset outputs.
    logic wd_out_n_reg, wd_out_n_next;

    always_comb begin
        wd_out_n_next = wd_out_n_reg;
        if (wd_hold) begin
            wd_out_n_next = 1'b1;
        end else if (kick_edge) begin
            wd_out_n_next = 1'b1;
        end else if (wd_expire) begin
            wd_out_n_next = 1'b0;
        end
        if (!sup_ok) begin
            wd_out_n_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wd_out_n_reg <= WDOG_N_RST;
        end else begin
            wd_out_n_reg <= wd_out_n_next;
        end
    end

    // ------------------------------------------------------------------
    // Reset outputs
    // ------------------------------------------------------------------
    // Both pins are taken from the same next value, so they switch on the
    // same edge and never disagree for a cycle.
    logic reset_p_reg, reset_p_next;

    always_comb begin
        reset_p_next = ~reset_n_next;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reset_p_reg <= ~RESET_N_RST;
        end else begin
            reset_p_reg <= reset_p_next;
        end
    end

    // ------------------------------------------------------------------
    // Power-fail flag
    // ------------------------------------------------------------------
    // Driven from the aux comparator alone; the reset logic never gates
    // it, so it stays useful as an early warning.
    logic aux_fail_n_reg, aux_fail_n_next;

    always_comb begin
        aux_fail_n_next = ~aux_low;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            aux_fail_n_reg <= AUX_N_RST;
        end else begin
            aux_fail_n_reg <= aux_fail_n_next;
        end
    end

    // ------------------------------------------------------------------
    // Output pins
    // ------------------------------------------------------------------
    // Every pin comes straight from a flop.
    assign reset_n = reset_n_reg;
    assign reset_p = reset_p_reg;
    assign watchdog_timeout_n = wd_out_n_reg;
    assign aux_fail_n = aux_fail_n_reg;
endmodule : ssw_supervisor

//--- ssw_supervisor_checker.sv
module ssw_chk #(
    parameter logic [31:0] RESET_CYC = 32'h0000_0014,
    parameter logic [31:0] WDOG_CYC = 32'h0000_0032
) (
    input logic clk,
    input logic srst,
    input logic supply_good,
    input logic aux_below_trip,
    input logic kick_floating,
    input logic manual_reset_n,
    input logic watchdog_kick_in,
    input logic reset_n,
    input logic reset_p,
    input logic watchdog_timeout_n,
    input logic aux_fail_n
);
    // ------
    // Good-time and idle-time counters.
    // ------
    logic [31:0] ok_reg, idle_reg;
    logic kick_reg;
    always_ff @(posedge clk) begin
        kick_reg <= watchdog_kick_in;
        ok_reg <= (srst | ~(supply_good & manual_reset_n)) ? '0 : ok_reg + 32'h1;
        idle_reg <= (srst | ~reset_n | kick_floating |
            (watchdog_kick_in != kick_reg)) ? '0 : idle_reg + 32'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_calm;
        (supply_good & reset_n & ~kick_floating & $stable(watchdog_kick_in))[*4];
    endsequence
    a_reset_inverse: assert property (reset_p == !reset_n) else $error("inv");
    a_supply_drop: assert property (!supply_good |-> ##[1:3] !reset_n)
        else $error("drop");
    a_wdog_forced: assert property (!supply_good |-> ##[1:3] !watchdog_timeout_n)
        else $error("wdo forced");
    a_aux_low: assert property (aux_below_trip[*4] |=> !aux_fail_n)
        else $error("aux low");
    a_aux_high: assert property (!aux_below_trip[*4] |=> aux_fail_n)
        else $error("aux high");
    a_manual_reset: assert property (!manual_reset_n |-> ##[1:3] !reset_n)
        else $error("manual");
    a_stretch_min: assert property ($rose(reset_n) |-> ok_reg >= RESET_CYC)
        else $error("short pulse");
    a_stretch_max: assert property (ok_reg == RESET_CYC + 6 |-> reset_n)
        else $error("long pulse");
    a_wdog_min: assert property (s_calm ##0 $fell(watchdog_timeout_n) |->
        idle_reg >= WDOG_CYC) else $error("early timeout");
    a_wdog_hold: assert property (s_calm ##0 !watchdog_timeout_n |=>
        !watchdog_timeout_n) else $error("wdo released");
    a_float_clear: assert property ((kick_floating & supply_good)[*4] |=>
        watchdog_timeout_n) else $error("float");
endmodule : ssw_chk
bind ssw_supervisor ssw_chk #(.RESET_CYC(RESET_CYC), .WDOG_CYC(WDOG_CYC))
    ssw_chk_inst (.clk(clk), .srst(srst), .supply_good(supply_good),
    .aux_below_trip(aux_below_trip), .kick_floating(kick_floating),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .reset_n(reset_n), .reset_p(reset_p), .aux_fail_n(aux_fail_n),
    .watchdog_timeout_n(watchdog_timeout_n));

//--- ssw_proc.sv
module ssw_proc (
    input logic clk,
    input logic reset_n,
    input logic run,
    output logic kick
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Processor kicks every 16 cycles; a halted core simply stops.
    // ------
    logic [3:0] cnt = 4'h0;
    initial kick = 1'b0;
    always @(negedge clk) begin
        if (run && reset_n) begin
            cnt <= cnt + 4'h1;
            if (cnt == 4'hF) kick <= ~kick;
        end
    end
endmodule : ssw_proc

//--- ssw_supervisor_tb.sv
module ssw_supervisor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------
    // Small counts keep the run short.
    // ------
    localparam int RC = 20;
    localparam int WC = 50;
    logic clk = 1'b0, srst = 1'b1, sg = 1'b0, aux = 1'b0, flt = 1'b0;
    logic mr_n = 1'b1, loop = 1'b0, run = 1'b0, kick, mr_pin;
    logic pf_loop = 1'b0;
    logic rst_n, rst_p, wdo_n, aux_n;
    int errors = 0, n_checks = 0, cyc = 0;
    always #2 clk = ~clk;
    assign mr_pin = mr_n & (loop ? wdo_n : 1'b1) &
        (pf_loop ? aux_n : 1'b1);
    ssw_supervisor #(.RESET_CYC(32'(RC)), .WDOG_CYC(32'(WC)))
        ssw_supervisor_inst (.clk(clk), .srst(srst), .supply_good(sg),
        .aux_below_trip(aux), .kick_floating(flt), .manual_reset_n(mr_pin),
        .watchdog_kick_in(kick), .reset_n(rst_n), .reset_p(rst_p),
        .watchdog_timeout_n(wdo_n), .aux_fail_n(aux_n));
    ssw_proc ssw_proc_inst (.clk(clk), .reset_n(rst_n), .run(run), .kick(kick));
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(negedge clk);
    endtask : cy
    task automatic close_out;
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    task automatic t_brown;
        sg = 1'b0;
        cy(8);
        chk(rst_n, 1'b0);
        chk(wdo_n, 1'b0);
        sg = 1'b1;
        cy(4);
        chk(wdo_n, 1'b1);
        cy(RC / 2);
        sg = 1'b0;
        cy(2);
        sg = 1'b1;
        cy(RC - 4);
        chk(rst_n, 1'b0);
        cy(10);
        chk(rst_n, 1'b1);
    endtask : t_brown
    task automatic t_mr;
        mr_n = 1'b0;
        cy(3);
        mr_n = 1'b1;
        cy(RC - 2);
        chk(rst_n, 1'b0);
        cy(10);
        chk(rst_n, 1'b1);
    endtask : t_mr
    task automatic t_pf;
        pf_loop = 1'b1;
        aux = 1'b1;
        cy(8);
        chk(rst_n, 1'b0);
        aux = 1'b0;
        cy(RC + 10);
        chk(rst_n, 1'b1);
        pf_loop = 1'b0;
    endtask : t_pf
    task automatic t_wdog;
        run = 1'b1;
        cy(3 * WC);
        chk(wdo_n, 1'b1);
        run = 1'b0;
        cy(WC - 20);
        chk(wdo_n, 1'b1);
        cy(30);
        chk(wdo_n, 1'b0);
        flt = 1'b1;
        cy(2 * WC);
        chk(wdo_n, 1'b1);
        flt = 1'b0;
        run = 1'b1;
        cy(20);
        run = 1'b0;
        loop = 1'b1;
        cy(WC + 8);
        chk(rst_n, 1'b0);
        cy(RC + 30);
        chk(rst_n, 1'b1);
        chk(wdo_n, 1'b1);
    endtask : t_wdog
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            close_out();
        end
    end
    initial begin
        cy(6);
        srst = 1'b0;
        sg = 1'b1;
        cy(RC);
        chk(rst_n, 1'b0);
        cy(6);
        chk(rst_n, 1'b1);
        chk(rst_p, 1'b0);
        t_brown();
        t_mr();
        aux = 1'b1;
        cy(5);
        chk(aux_n, 1'b0);
        aux = 1'b0;
        cy(5);
        chk(aux_n, 1'b1);
        t_pf();
        t_wdog();
        close_out();
    end
endmodule : ssw_supervisor_tb
